// ===== inc/dsc_pkg.sv
// Shared constants and types of the four-channel diagnosis slave.
package dsc_pkg;
	// Core clock rate in MHz, used to turn times into cycle counts.
	localparam int CLK_MHZ = 40;
	// Open-load delay, shortest allowed, in microseconds.
	localparam int OL_DELAY_US = 30;
	// Overload switch-off delay, shortest allowed, in microseconds.
	localparam int OVL_DELAY_US = 5;

	// Converts a whole number of microseconds to core clock cycles.
	function automatic int us_to_cyc(input int us);
		return us * CLK_MHZ;
	endfunction

	// Counter widths and terminal counts for the two delays.
	localparam int OL_CNT_W = 11;
	localparam int OVL_CNT_W = 8;
	localparam logic [OL_CNT_W-1:0] OL_CYC = OL_CNT_W'(us_to_cyc(OL_DELAY_US));
	localparam logic [OVL_CNT_W-1:0] OVL_CYC = OVL_CNT_W'(us_to_cyc(OVL_DELAY_US));

	// Frame geometry and field layout.
	localparam int NCHAN = 4;
	localparam int BYTE_W = 8;
	localparam int MODE_W = 2;
	localparam logic [2:0] BIT_CNT_ZERO = 3'h0;
	localparam logic [2:0] BIT_CNT_ONE = 3'h1;

	// Reset values.
	localparam logic [BYTE_W-1:0] MODE_RST = 8'h00;
	localparam logic [BYTE_W-1:0] SNAP_RST = 8'h00;
	localparam logic TER_RST = 1'h1;

	// Per-channel mode field codes.
	typedef enum logic [1:0] {
		DSC_MODE_IDLE = 2'h0,
		DSC_MODE_DIRECT = 2'h1,
		DSC_MODE_ON = 2'h2,
		DSC_MODE_OFF = 2'h3
	} dsc_mode_type;
endpackage

// ===== inc/dsc_link_if.sv
`timescale 1ns/100ps
// Signals that pass between the serial-clock logic and the core logic.
interface dsc_link_if;
	// Shift register contents, frozen once the serial clock stops.
	logic [7:0] shift_word;
	// Rising serial-clock edges counted modulo eight.
	logic [2:0] bit_cnt;
	// Toggles once in every frame that carries at least one clock.
	logic frame_tog;
	// Serial output level towards the pin.
	logic sout;
	// Error flag from the core, steady during a frame.
	logic frame_error_flag;
	// Status byte captured by the core at the select fall.
	logic [7:0] snap_word;
	modport link (output shift_word, output bit_cnt, output frame_tog, output sout,
		input frame_error_flag, input snap_word);
	modport core (input shift_word, input bit_cnt, input frame_tog, input sout,
		output frame_error_flag, output snap_word);
endinterface

// ===== rtl/dsc_spi_link.sv
`timescale 1ns/100ps
// Serial-clock side of the slave port; the select pin closes the frame.
module dsc_spi_link (
	input wire logic sclk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic si,
	dsc_link_if.link lk
);
	// Reset of the per-frame flags: any reset or a deselected port.
	logic frame_rst;
	// High until the first rising edge of the frame.
	logic first_rise_q;
	// High until the first falling edge of the frame.
	logic first_fall_q;
	// Registered serial output bit.
	logic so_q;
	logic [7:0] shift_q;
	logic [2:0] cnt_q;
	logic tog_q;

	assign frame_rst = rst | cs_n;

	// [RQ9] select high clears frame state.
	always_ff @(posedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			first_rise_q <= 1'h1;
		end else begin
			first_rise_q <= 1'h0;
		end
	end

	// The falling-edge flag mirrors the rising one in its own edge.
	always_ff @(negedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			first_fall_q <= 1'h1;
		end else begin
			first_fall_q <= 1'h0;
		end
	end

	// [RQ10] output changes on rising edge.
	// The first rise of a frame restarts the count and flips the frame toggle.
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			so_q <= 1'h0;
			cnt_q <= dsc_pkg::BIT_CNT_ZERO;
			tog_q <= 1'h0;
		end else if (!cs_n) begin
			if (first_rise_q) begin
				// [RQ11] status MSB goes out first.
				so_q <= lk.snap_word[7];
				cnt_q <= dsc_pkg::BIT_CNT_ONE;
				tog_q <= ~tog_q;
			end else begin
				so_q <= shift_q[7];
				cnt_q <= cnt_q + 3'h1;
			end
		end
	end

	// [RQ18] shift one input bit per clock.
	// The first fall takes the snapshot in place of the old contents.
	always_ff @(negedge sclk or posedge rst) begin
		if (rst) begin
			shift_q <= dsc_pkg::SNAP_RST;
		end else if (!cs_n) begin
			shift_q <= first_fall_q ? {lk.snap_word[6:0], si} : {shift_q[6:0], si};
		end
	end

	// [RQ13] error OR input before first rise.
	assign lk.sout = first_rise_q ? (lk.frame_error_flag | si) : so_q;
	assign lk.shift_word = shift_q;
	assign lk.bit_cnt = cnt_q;
	assign lk.frame_tog = tog_q;

	// Checks in the serial-clock domain.
	first_bit_a: assert property (@(posedge sclk) disable iff (rst) // [RQ11]
		(!cs_n && first_rise_q) |=> (so_q == $past(lk.snap_word[7])))
		else $error("first output bit is not the status MSB");
endmodule

// ===== rtl/dsc_chan_diag.sv
`timescale 1ns/100ps
// One output channel: switching, protective shutdown and open-load watch.
module dsc_chan_diag (
	input wire logic clk,
	input wire logic rst,
	input dsc_pkg::dsc_mode_type mode,
	input wire logic mode_wr,
	input wire logic in_pin,
	input wire logic ol_sense,
	input wire logic ovl_sense,
	input wire logic otemp_sense,
	output logic chan_on,
	output logic pulldown_diag_current,
	output logic open_load_flag,
	output logic protect_shutdown_flag
);
	logic [dsc_pkg::OL_CNT_W-1:0] ol_cnt_q;
	logic [dsc_pkg::OVL_CNT_W-1:0] ovl_cnt_q;
	// Commanded conduction before protection is applied.
	logic on_cmd;
	// Open-load watch is allowed only with the channel commanded off.
	logic ol_window;
	logic ol_set;
	logic prot_set;
	// A write of the idle code clears both flags.
	logic flag_clr;

	assign on_cmd = (mode == dsc_pkg::DSC_MODE_ON) || ((mode == dsc_pkg::DSC_MODE_DIRECT) && in_pin);
	// [RQ5] no open-load watch while conducting.
	assign ol_window = (mode == dsc_pkg::DSC_MODE_OFF) || ((mode == dsc_pkg::DSC_MODE_DIRECT) && !in_pin);
	assign ol_set = ol_window && ol_sense && (ol_cnt_q == dsc_pkg::OL_CYC - 1'h1);
	// [RQ6] over-temperature trips in any state.
	assign prot_set = otemp_sense || (chan_on && ovl_sense && (ovl_cnt_q == dsc_pkg::OVL_CYC - 1'h1));
	assign flag_clr = mode_wr && (mode == dsc_pkg::DSC_MODE_IDLE);

	// [RQ8] glitches shorter than the delay restart the count.
	// [RQ3] [RQ4] open-load delay counter.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ol_cnt_q <= '0;
		end else if (ol_window && ol_sense && !ol_set) begin
			ol_cnt_q <= ol_cnt_q + 1'h1;
		end else begin
			ol_cnt_q <= '0;
		end
	end

	// [RQ7] overload delay counter while conducting.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ovl_cnt_q <= '0;
		end else if (chan_on && ovl_sense && !prot_set) begin
			ovl_cnt_q <= ovl_cnt_q + 1'h1;
		end else begin
			ovl_cnt_q <= '0;
		end
	end

	// [RQ1] [RQ2] latched flags, set wins over clear.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			open_load_flag <= 1'h0;
			protect_shutdown_flag <= 1'h0;
		end else begin
			open_load_flag <= ol_set | (open_load_flag & ~flag_clr);
			protect_shutdown_flag <= prot_set | (protect_shutdown_flag & ~flag_clr);
		end
	end

	// [RQ21] drive and pull-down follow the mode; a tripped channel stays off.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chan_on <= 1'h0;
			pulldown_diag_current <= 1'h0;
		end else begin
			chan_on <= on_cmd && !prot_set && !protect_shutdown_flag;
			pulldown_diag_current <= (mode != dsc_pkg::DSC_MODE_IDLE);
		end
	end

	ol_delay_a: assert property (@(posedge clk) disable iff (rst) // [RQ3]
		$rose(open_load_flag) |-> ($past(ol_cnt_q) == dsc_pkg::OL_CYC - 1'h1))
		else $error("open-load flag rose before the delay");
	prot_off_a: assert property (@(posedge clk) disable iff (rst) // [RQ6]
		protect_shutdown_flag |-> !chan_on)
		else $error("channel conducts with protective flag set");
	idle_clear_a: assert property (@(posedge clk) disable iff (rst) // [RQ2]
		(flag_clr && !ol_set) |=> !open_load_flag)
		else $error("idle write did not clear open-load flag");
endmodule

// ===== rtl/dsc_top.sv
`timescale 1ns/100ps
// Operation
// [RQ1] Latch protective and open-load flag per channel.
// [RQ2] Idle mode write clears flags, pull-down off.
// [RQ3] Direct mode, input low: open-load after delay.
// [RQ4] Forced-off mode: open-load after delay.
// [RQ5] No open-load watch while channel conducts.
// [RQ6] Over-temperature switches off, sets flag always.
// [RQ7] Overload switches off after delay, sets flag.
// [RQ8] Short open-load glitches are filtered out.
// [RQ9] Select high: ignore clock, output floats.
// [RQ10] Sample input on fall, shift on rise.
// [RQ11] Most significant bit first both directions.
// [RQ12] Select fall loads flags into shift register.
// [RQ13] Before first rise output error OR input.
// [RQ14] Any reset sets the error flag.
// [RQ15] Select rise stores byte on nonzero multiple-eight.
// [RQ16] Host ends each access raising select.
// [RQ17] Host keeps clock low at select edges.
// [RQ18] One bit per clock, shift-out enables chaining.
// [RQ19] Chain of N needs N bytes shifted.
// [RQ20] Reset returns serial state to default.
// [RQ21] Two-bit mode per channel, fixed codes.
// [RQ22] Status byte: open-load, protective pairs, MSB.
// [RQ23] Reset clears mode and status bits.
// [RQ24] Pins synchronised before edges are detected.
module dsc_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	output logic so_o,
	output logic so_oe_n,
	input wire logic [3:0] in_pin,
	input wire logic [3:0] ol_sense,
	input wire logic [3:0] ovl_sense,
	input wire logic [3:0] otemp_sense,
	output logic [3:0] chan_on,
	output logic [3:0] pulldown_diag_current,
	output logic [3:0] open_load_flag,
	output logic [3:0] protect_shutdown_flag,
	output logic [7:0] channel_mode_field,
	output logic frame_error_flag
);
	// Width of the synchroniser vector: select, toggle and four groups of four.
	localparam int SYNC_W = 18;
	// Bit position of the select pin within the vector.
	localparam int SYNC_CS = 17;
	// Bit position of the frame toggle within the vector.
	localparam int SYNC_TOG = 16;
	// Select idles high, everything else low.
	localparam logic [SYNC_W-1:0] SYNC_RST = 18'h20000;

	// Carrier between the serial-clock logic and this core.
	dsc_link_if lk ();

	// Three flip-flop stages of the synchroniser.
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic [SYNC_W-1:0] sync3_q;
	// Filtered value that moves only when stages two and three agree.
	logic [SYNC_W-1:0] filt_q;
	// Previous filtered select, for edge detection.
	logic cs_prev_q;
	// Select edge events in the core domain, one cycle each.
	logic cs_fall;
	logic cs_rise;
	// Frame toggle last seen at a select rise.
	logic tog_seen_q;
	// High when the closing frame ended on a whole, nonzero byte count.
	logic frame_ok;
	// Mode register and its one-cycle write strobe.
	logic [7:0] mode_q;
	logic mode_wr_q;
	// Error flag and the captured status byte.
	logic ter_q;
	logic [7:0] snap_q;
	// Live status byte assembled from the channel flags.
	logic [7:0] status_word;
	// Synchronised views of the analog and input pins.
	logic [3:0] in_s;
	logic [3:0] ol_s;
	logic [3:0] ovl_s;
	logic [3:0] ot_s;
	// Channel results before they leave through the ports.
	logic [3:0] ch_on;
	logic [3:0] ch_pd;
	logic [3:0] ch_ol;
	logic [3:0] ch_prot;

	// Agreement filter: a bit follows the synchroniser only when the last two stages match.
	function automatic logic [SYNC_W-1:0] agree(input logic [SYNC_W-1:0] a, input logic [SYNC_W-1:0] b,
		input logic [SYNC_W-1:0] hold);
		return (a & b) | (hold & (a | b));
	endfunction

	// The serial-clock logic runs on the host clock and uses select as its frame reset.
	dsc_spi_link u_link (
		.sclk(sclk),
		.rst(rst),
		.cs_n(cs_n),
		.si(si),
		.lk(lk.link)
	);

	// [RQ24] three-stage pin synchroniser.
	// The first stage feeds only the second; the filter reads stages two and three.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_q <= SYNC_RST;
			sync2_q <= SYNC_RST;
			sync3_q <= SYNC_RST;
			filt_q <= SYNC_RST;
		end else begin
			sync1_q <= {cs_n, lk.frame_tog, in_pin, ol_sense, ovl_sense, otemp_sense};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			filt_q <= agree(sync2_q, sync3_q, filt_q);
		end
	end

	// Unpack the filtered pin groups for the channels.
	assign in_s = filt_q[15:12];
	assign ol_s = filt_q[11:8];
	assign ovl_s = filt_q[7:4];
	assign ot_s = filt_q[3:0];

	// Remember the previous select level for edge detection.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_prev_q <= 1'h1;
		end else begin
			cs_prev_q <= filt_q[SYNC_CS];
		end
	end

	assign cs_fall = cs_prev_q && !filt_q[SYNC_CS];
	assign cs_rise = !cs_prev_q && filt_q[SYNC_CS];

	// [RQ15] whole nonzero byte count required.
	// A toggle that moved since the last rise means the frame saw at least one clock.
	// The count and shift word are read only here, when the serial clock is parked low.
	assign frame_ok = (filt_q[SYNC_TOG] != tog_seen_q) && (lk.bit_cnt == dsc_pkg::BIT_CNT_ZERO);

	// [RQ22] status byte layout, channel three in the top pair.
	assign status_word = {ch_ol[3], ch_prot[3], ch_ol[2], ch_prot[2],
		ch_ol[1], ch_prot[1], ch_ol[0], ch_prot[0]};

	// [RQ12] capture flags at select fall.
	// The host must leave a few core cycles before the first clock rise so the capture settles.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			snap_q <= dsc_pkg::SNAP_RST;
		end else if (cs_fall) begin
			snap_q <= status_word;
		end
	end

	// The seen toggle is updated at every select rise, valid or not.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tog_seen_q <= 1'h0;
		end else if (cs_rise) begin
			tog_seen_q <= filt_q[SYNC_TOG];
		end
	end

	// [RQ15] store mode byte on valid frame.
	// [RQ23] mode register clears at reset.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_q <= dsc_pkg::MODE_RST;
			mode_wr_q <= 1'h0;
		end else if (cs_rise && frame_ok) begin
			mode_q <= lk.shift_word;
			mode_wr_q <= 1'h1;
		end else begin
			mode_wr_q <= 1'h0;
		end
	end

	// [RQ14] [RQ20] error flag set by reset.
	// Each closing frame reports its own success in the next frame.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ter_q <= dsc_pkg::TER_RST;
		end else if (cs_rise) begin
			ter_q <= !frame_ok;
		end
	end

	assign lk.frame_error_flag = ter_q;
	assign lk.snap_word = snap_q;

	// One diagnosis slice per channel, fields taken from the bottom up.
	genvar ch;
	generate
		for (ch = 0; ch < dsc_pkg::NCHAN; ch++) begin : g_chan
			// [RQ21] field of channel ch.
			dsc_chan_diag u_chan (
				.clk(clk),
				.rst(rst),
				.mode(dsc_pkg::dsc_mode_type'(mode_q[2*ch+1 -: 2])),
				.mode_wr(mode_wr_q),
				.in_pin(in_s[ch]),
				.ol_sense(ol_s[ch]),
				.ovl_sense(ovl_s[ch]),
				.otemp_sense(ot_s[ch]),
				.chan_on(ch_on[ch]),
				.pulldown_diag_current(ch_pd[ch]),
				.open_load_flag(ch_ol[ch]),
				.protect_shutdown_flag(ch_prot[ch])
			);
		end
	endgenerate

	// Channel results are already registered inside each slice.
	assign chan_on = ch_on;
	assign pulldown_diag_current = ch_pd;
	assign open_load_flag = ch_ol;
	assign protect_shutdown_flag = ch_prot;
	assign channel_mode_field = mode_q;
	assign frame_error_flag = ter_q;

	// [RQ9] output floats while deselected.
	// The serial output must follow the pin directly; a core-clock register here
	// would arrive too late for a 48 ns serial clock, so the output and its enable are both pin-driven.
	assign so_oe_n = cs_n;
	assign so_o = lk.sout;

	// Checks in the core domain.
	ter_reset_a: assert property (@(posedge clk) // [RQ14]
		$fell(rst) |-> ter_q)
		else $error("error flag clear after reset");
	mode_hold_a: assert property (@(posedge clk) disable iff (rst) // [RQ15]
		!(cs_rise && frame_ok) |=> (mode_q == $past(mode_q)))
		else $error("mode changed without a valid frame");
	mode_load_a: assert property (@(posedge clk) disable iff (rst) // [RQ15]
		(cs_rise && frame_ok) |=> (mode_q == $past(lk.shift_word)) && mode_wr_q)
		else $error("valid frame not stored");
	ter_bad_a: assert property (@(posedge clk) disable iff (rst) // [RQ15]
		(cs_rise && !frame_ok) |=> ter_q)
		else $error("bad frame not flagged");
	snap_load_a: assert property (@(posedge clk) disable iff (rst) // [RQ12]
		cs_fall |=> (snap_q == $past(status_word)))
		else $error("status not captured at select fall");
	pd_idle_a: assert property (@(posedge clk) disable iff (rst) // [RQ2]
		(mode_q[1:0] == 2'h0) [*2] |-> !pulldown_diag_current[0])
		else $error("pull-down on in idle mode");
	edge_once_a: assert property (@(posedge clk) disable iff (rst) // [RQ24]
		cs_rise |=> !cs_rise)
		else $error("select edge counted twice");
	float_a: assert property (@(posedge clk) disable iff (rst) // [RQ9]
		cs_n |-> so_oe_n)
		else $error("output driven while deselected");

	valid_frame_c: cover property (@(posedge clk) disable iff (rst) cs_rise && frame_ok);
	bad_frame_c: cover property (@(posedge clk) disable iff (rst) cs_rise && !frame_ok);
	prot_trip_c: cover property (@(posedge clk) disable iff (rst) $rose(ch_prot[0]));
	ol_trip_c: cover property (@(posedge clk) disable iff (rst) $rose(ch_ol[3]));
endmodule

// ===== dv/dsc_host_model.sv
`timescale 1ns/100ps
// Host-side serial master: one select line, a clock that runs only inside frames.
module dsc_host_model (
	output logic sclk,
	output logic cs_n,
	output logic si,
	input wire logic so
);
	// Return level seen after the select fall, before the first clock rise.
	logic first_bit;

	// Idle pins: select high, clock parked low.
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		first_bit = 1'b0;
	end

	// One frame of nclk clocks at 48 ns; tx leaves from bit 15, rx fills from bit 0.
	task automatic xfer(input logic [15:0] tx, input int nclk, output logic [15:0] rx);
		rx = 16'h0000;
		sclk = 1'b0;
		cs_n = 1'b0;
		si = tx[15];
		// The slave needs a few core cycles to snapshot its flags.
		#200;
		first_bit = so;
		for (int i = 0; i < nclk; i++) begin
			sclk = 1'b1;
			#24;
			rx = {rx[14:0], so};
			sclk = 1'b0;
			// Data moves a little after the fall so the slave samples the old bit.
			#2;
			si = (i < 15) ? tx[14 - i] : ~si;
			#22;
		end
		#100;
		cs_n = 1'b1;
		// A released line shows the inverse, not a stale copy.
		si = ~si;
		#200;
	endtask
endmodule

// ===== dv/dsc_top_test.sv
`timescale 1ns/100ps
// Self-checking bench for the four-channel diagnosis slave.
module dsc_top_test;
	logic clk;
	logic rst;
	wire logic sclk;
	wire logic cs_n;
	wire logic si;
	logic so_o;
	logic so_oe_n;
	// The return line floats whenever the slave is not selected.
	wire logic so_line;
	logic [3:0] in_pin;
	logic [3:0] ol_sense;
	logic [3:0] ovl_sense;
	logic [3:0] otemp_sense;
	logic [3:0] chan_on;
	logic [3:0] pd;
	logic [3:0] olf;
	logic [3:0] psf;
	logic [7:0] mode;
	logic fef;
	logic [15:0] rx;
	int n_errors = 0;
	int compares = 0;
	// Delay figures in core cycles, worked out independently of the design.
	localparam int OL_N = dsc_pkg::OL_DELAY_US * dsc_pkg::CLK_MHZ;
	localparam int OVL_N = dsc_pkg::OVL_DELAY_US * dsc_pkg::CLK_MHZ;

	assign so_line = so_oe_n ? 1'bz : so_o;

	dsc_top dsc_top_i (
		.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si), .so_o(so_o), .so_oe_n(so_oe_n),
		.in_pin(in_pin), .ol_sense(ol_sense), .ovl_sense(ovl_sense), .otemp_sense(otemp_sense),
		.chan_on(chan_on), .pulldown_diag_current(pd), .open_load_flag(olf),
		.protect_shutdown_flag(psf), .channel_mode_field(mode), .frame_error_flag(fef)
	);

	dsc_host_model dsc_host_model_i (
		.sclk(sclk), .cs_n(cs_n), .si(si), .so(so_line)
	);

	// 40 MHz core clock.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Compares one value and counts it.
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	// Lets n edges pass, then a little more so their updates have landed.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One frame, then enough core cycles for the commit to reach the ports.
	task automatic frame(input logic [15:0] tx, input int n);
		dsc_host_model_i.xfer(tx, n, rx);
		cyc(12);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		in_pin = 4'h0;
		ol_sense = 4'h0;
		ovl_sense = 4'h0;
		otemp_sense = 4'h0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		cyc(2);
		check("mode", mode, 8'h00);
		check("flags", {olf, psf}, 8'h00);
		check("error", 8'(fef), 8'h01);
		check("so_oe_n", 8'(so_oe_n), 8'h01);
		$display("test reset done");

		// Ch3 idle, ch2 direct, ch1 forced on, ch0 forced off.
		frame({8'h1B, 8'h00}, 8);
		check("first bit", 8'(dsc_host_model_i.first_bit), 8'h01);
		check("status", rx[7:0], 8'h00);
		check("mode", mode, 8'h1B);
		check("error", 8'(fef), 8'h00);
		check("chan_on", 8'(chan_on), 8'h02);
		check("pulldown", 8'(pd), 8'h07);
		@(posedge clk) in_pin <= 4'hF;
		cyc(10);
		check("chan_on", 8'(chan_on), 8'h06);
		@(posedge clk) in_pin <= 4'h0;
		cyc(10);
		$display("test mode write done");

		// A short frame and an empty frame are refused.
		frame({8'hFF, 8'h00}, 7);
		check("mode", mode, 8'h1B);
		check("error", 8'(fef), 8'h01);
		frame(16'h0000, 0);
		check("first bit", 8'(dsc_host_model_i.first_bit), 8'h01);
		check("mode", mode, 8'h1B);
		// Two bytes: the first comes back out, the last one is kept.
		frame({8'hA5, 8'h1B}, 16);
		check("chained", rx[7:0], 8'hA5);
		check("mode", mode, 8'h1B);
		frame({8'h1B, 8'h00}, 8);
		check("first bit", 8'(dsc_host_model_i.first_bit), 8'h00);
		$display("test framing done");

		// Open load on ch0, ch1, ch2; ch2 glitches once halfway.
		@(posedge clk) ol_sense <= 4'h7;
		cyc(OL_N / 2);
		// The dip must outlast the pin filter, or it never reaches the counter.
		@(posedge clk) ol_sense <= 4'h3;
		cyc(5);
		@(posedge clk) ol_sense <= 4'h7;
		cyc(OL_N / 2 - 12);
		check("open load", 8'(olf), 8'h00);
		cyc(30);
		check("open load", 8'(olf), 8'h01);
		cyc(OL_N / 2 + 20);
		check("open load", 8'(olf), 8'h05);
		check("open load", 8'(olf), 8'h05);
		check("open load", 8'(olf), 8'h05);
		$display("test open load done");

		// Overload on the conducting ch1.
		@(posedge clk) ovl_sense <= 4'h2;
		cyc(OVL_N - 10);
		check("chan_on", 8'(chan_on), 8'h02);
		cyc(30);
		check("chan_on", 8'(chan_on), 8'h00);
		check("protect", 8'(psf), 8'h02);
		@(posedge clk) ovl_sense <= 4'h0;
		// Over-temperature on the switched-off ch0.
		@(posedge clk) otemp_sense <= 4'h1;
		cyc(10);
		@(posedge clk) otemp_sense <= 4'h0;
		cyc(2);
		check("protect", 8'(psf), 8'h03);
		check("protect", 8'(psf), 8'h03);
		$display("test protection done");

		// Read the flags back while idling ch1 and ch0.
		@(posedge clk) ol_sense <= 4'h4;
		frame({8'h50, 8'h00}, 8);
		check("status", rx[7:0], 8'h27);
		check("mode", mode, 8'h50);
		check("open load", 8'(olf), 8'h04);
		check("protect", 8'(psf), 8'h00);
		check("pulldown", 8'(pd), 8'h0C);
		$display("test clear done");

		// Reset in mid-run.
		@(posedge clk) rst <= 1'b1;
		cyc(2);
		@(posedge clk) rst <= 1'b0;
		cyc(2);
		check("mode", mode, 8'h00);
		check("error", 8'(fef), 8'h01);
		check("flags", {olf, psf}, 8'h00);
		frame({8'h00, 8'h00}, 8);
		check("first bit", 8'(dsc_host_model_i.first_bit), 8'h01);
		check("error", 8'(fef), 8'h00);
		$display("test reset again done");
		finish_test();
	end
endmodule
